/* File: pkg/smpc_consts.svh */
// constants of the sleep mode power controller
// Notes on behaviour
// R1: sleep needs enable bit, then sleep instruction
// R2: interrupt wake: stall four cycles after startup
// R3: register file and data memory kept unchanged
// R4: reset during sleep restarts at reset vector
// R5: mode 000 idle stops core and flash clocks
// R6: idle wakes on any enabled interrupt
// R7: idle or noise mode starts a conversion
// R8: mode 001 also stops peripheral clock
// R9: noise mode wakes on listed sources only
// R10: mode 010 power-down stops every generated clock
// R11: power-down wakes on listed sources only
// R12: level wake must be held by source
// R13: power-down wake waits fuse start-up time
// R14: mode 011 power-save keeps async timer counting
// R15: power-save timer wake needs both enables
// R16: power-save oscillators follow timer clock choice
// R17: mode 110 with crystal gives standby
// R18: standby resumes within six clock cycles
// R19: gate bit stops peripheral clock, freezes state
// R20: clearing gate bit restarts in held state
// R21: gating applies in active and idle only; the gate bits here also stop the ADC clock in noise and the ATIM clock in noise and power-save
// R22: control register layout, upper bits zero
// R23: codes 100, 101, 111 are reserved
// R24: gate register bit map, bit 4 zero
// R25: reserved code makes sleep a no-op
// R26: sleep without enable is a no-op
`ifndef SMPC_CONSTS_SVH
`define SMPC_CONSTS_SVH
`define SMPC_SLEEP_EN_BIT  0
`define SMPC_MODE_LSB      1
`define SMPC_MODE_MSB      3
`define SMPC_CTRL_MASK     8'h0F
`define SMPC_CTRL_RST      8'h00
`define SMPC_GATE_MASK     8'hEF
`define SMPC_GATE_RST      8'h00
`define SMPC_GATE_TWO_WIRE 7
`define SMPC_GATE_ATIM     6
`define SMPC_GATE_TIM0     5
`define SMPC_GATE_TIM1     3
`define SMPC_GATE_SPI      2
`define SMPC_GATE_UART     1
`define SMPC_GATE_ADC      0
`define SMPC_MODE_IDLE     3'h0
`define SMPC_MODE_NOISE    3'h1
`define SMPC_MODE_PDOWN    3'h2
`define SMPC_MODE_PSAVE    3'h3
`define SMPC_MODE_STBY     3'h6
`define SMPC_IRQ_STALL     4
`define SMPC_STBY_CYC      6
`define SMPC_CNT_W         16
`endif

/* File: pkg/smpc_pkg.sv */
// types of the sleep mode power controller
package smpc_pkg;
   typedef enum logic [2:0] {
      SMPC_RUN   = 3'h0,
      SMPC_SLEEP = 3'h1,
      SMPC_START = 3'h2,
      SMPC_STALL = 3'h3
   } smpc_state_e;

   // clock domain enables, high = running
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic asy;
      logic main_osc;
      logic timer_osc;
   } smpc_clk_s;

   // wake sources, already qualified by their own enables
   typedef struct packed {
      logic ext_level;
      logic ext_edge;
      logic pin_change;
      logic two_wire_match;
      logic atim_irq;
      logic store_ready;
      logic adc_done;
      logic monitor_irq;
      logic other_irq;
   } smpc_wake_s;
endpackage : smpc_pkg

/* File: rtl/smpc_wait.sv */
// down counter that times a wake-up delay
module smpc_wait #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   // status
   output logic              done
);
   logic [W-1:0] cnt_r;
   logic         busy_r;

   always_ff @(posedge clk)
   begin
      if (srst || load)
      begin
         cnt_r  <= srst ? '0 : count;
         busy_r <= !srst;
      end
      else if (busy_r)
      begin
         if (cnt_r <= W'(1))
            busy_r <= 1'b0;
         cnt_r <= cnt_r - W'(1);
      end
   end

   assign done = busy_r && (cnt_r <= W'(1));
endmodule : smpc_wait

/* File: rtl/smpc_ctrl.sv */
// sleep mode and per-peripheral clock gate controller
`include "smpc_consts.svh"
module smpc_ctrl #(
   parameter int CNT_W = `SMPC_CNT_W
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // register writes from the core
   input  wire logic                  ctrl_we,
   input  wire logic [7:0]            ctrl_wdata,
   input  wire logic                  gate_we,
   input  wire logic [7:0]            gate_wdata,
   // register read-back
   output logic [7:0]                 ctrl_rdata,
   output logic [7:0]                 gate_rdata,
   // core handshake
   input  wire logic                  sleep_exec,
   input  wire logic                  irq_global_en,
   output logic                       core_halt,
   output logic                       sleeping,
   output logic                       reset_vector,
   // wake sources from interrupt system
   input  wire smpc_pkg::smpc_wake_s  wake_in,
   input  wire logic                  wake_reset,
   // configuration
   input  wire logic                  xtal_selected,
   input  wire logic                  atim_async,
   input  wire logic                  atim_enabled,
   input  wire logic                  adc_enabled,
   input  wire logic [CNT_W-1:0]      fuse_startup,
   // clock enables and side effects
   output smpc_pkg::smpc_clk_s        clk_en,
   output logic [7:0]                 periph_clk_en,
   output logic                       atim_sync_clk_en,
   output logic                       adc_start
);
   import smpc_pkg::*;

   // ************************************************
   // registers
   // ************************************************
   logic [7:0]  ctrl_r;
   logic [7:0]  gate_r;
   logic [2:0]  mode_r;
   smpc_state_e st_r;
   smpc_state_e st_nxt;
   logic        rstvec_r;
   logic        adc_start_r;
   logic        wait_load;
   logic [CNT_W-1:0] wait_cnt;
   logic        wait_done;
   logic        stall_load;
   logic        stall_done;
   logic        wake_any;
   logic        go_sleep;

   function automatic logic mode_legal(input logic [2:0] m,
                                       input logic       xtal);
      mode_legal = (m == `SMPC_MODE_IDLE) || (m == `SMPC_MODE_NOISE) ||
                   (m == `SMPC_MODE_PDOWN) || (m == `SMPC_MODE_PSAVE) ||
                   ((m == `SMPC_MODE_STBY) && xtal); // [R17] [R23]
   endfunction : mode_legal

   function automatic logic mode_deep(input logic [2:0] m);
      mode_deep = (m == `SMPC_MODE_PDOWN) || (m == `SMPC_MODE_PSAVE) ||
                  (m == `SMPC_MODE_STBY);
   endfunction : mode_deep

   always_ff @(posedge clk)
   begin
      if (srst)
         ctrl_r <= `SMPC_CTRL_RST;
      else if (ctrl_we)
         ctrl_r <= ctrl_wdata & `SMPC_CTRL_MASK; // [R22]
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         gate_r <= `SMPC_GATE_RST;
      else if (gate_we)
         gate_r <= gate_wdata & `SMPC_GATE_MASK; // [R24]
   end

   assign ctrl_rdata = ctrl_r;
   assign gate_rdata = gate_r;

   // ************************************************
   // sleep sequencing
   // ************************************************
   // no-op unless enabled and a legal mode is chosen
   assign go_sleep = sleep_exec && ctrl_r[`SMPC_SLEEP_EN_BIT] &&
      mode_legal(ctrl_r[`SMPC_MODE_MSB:`SMPC_MODE_LSB],
                 xtal_selected); // [R1] [R25] [R26]

   always_comb
   begin
      wake_any = 1'b0;
      unique case (mode_r)
         `SMPC_MODE_IDLE:
            wake_any = |wake_in; // [R6]
         `SMPC_MODE_NOISE:
            wake_any = wake_in.adc_done || wake_in.monitor_irq ||
                       wake_in.two_wire_match || wake_in.store_ready ||
                       wake_in.ext_level || wake_in.pin_change ||
                       (wake_in.atim_irq && atim_async); // [R9]
         `SMPC_MODE_PSAVE:
            wake_any = wake_in.monitor_irq || wake_in.two_wire_match ||
                       wake_in.ext_level || wake_in.pin_change ||
                       (wake_in.atim_irq && irq_global_en); // [R15]
         default:
            wake_any = wake_in.monitor_irq || wake_in.two_wire_match ||
                       wake_in.ext_level || wake_in.pin_change; // [R11]
      endcase
   end

   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         SMPC_RUN:
            if (go_sleep)
               st_nxt = SMPC_SLEEP;
         SMPC_SLEEP:
            if (wake_any)
               st_nxt = SMPC_START;
         SMPC_START:
            if (wait_done)
               st_nxt = SMPC_STALL;
         SMPC_STALL:
            if (stall_done)
               st_nxt = SMPC_RUN;
         default:
            st_nxt = SMPC_RUN;
      endcase
   end

   // reset wakes the core straight to the vector
   always_ff @(posedge clk)
   begin
      if (srst)
         st_r <= SMPC_RUN;
      else if (wake_reset)
         st_r <= SMPC_RUN; // [R4]
      else
         st_r <= st_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rstvec_r <= 1'b0;
      else
         rstvec_r <= wake_reset && (st_r != SMPC_RUN); // [R4]
   end
   assign reset_vector = rstvec_r;

   always_ff @(posedge clk)
   begin
      if (srst)
         mode_r <= `SMPC_MODE_IDLE;
      else if (st_r == SMPC_RUN && go_sleep)
         mode_r <= ctrl_r[`SMPC_MODE_MSB:`SMPC_MODE_LSB]; // [R5] [R8]
   end

   // start-up delay: fuse time for deep modes, six for standby
   assign wait_load = (st_r == SMPC_SLEEP) && wake_any && !wake_reset;
   always_comb
   begin
      if (mode_r == `SMPC_MODE_STBY)
         wait_cnt = CNT_W'(`SMPC_STBY_CYC); // [R18]
      else if (mode_deep(mode_r))
         wait_cnt = fuse_startup; // [R13]
      else
         wait_cnt = CNT_W'(1);
   end

   smpc_wait #(.W(CNT_W)) u_startup (
      .clk   (clk),
      .srst  (srst || wake_reset),
      .load  (wait_load),
      .count (wait_cnt),
      .done  (wait_done)
   );

   assign stall_load = (st_r == SMPC_START) && wait_done;
   smpc_wait #(.W(CNT_W)) u_stall (
      .clk   (clk),
      .srst  (srst || wake_reset),
      .load  (stall_load),
      .count (CNT_W'(`SMPC_IRQ_STALL)),
      .done  (stall_done)
   ); // [R2]

   // core only halted; its storage is never touched here
   assign core_halt = (st_r != SMPC_RUN); // [R3]
   assign sleeping  = (st_r == SMPC_SLEEP);

   // ************************************************
   // clock domains
   // ************************************************
   always_comb
   begin
      clk_en = '{cpu:1'b1, flash:1'b1, io:1'b1, adc:1'b1, asy:1'b1,
                 main_osc:1'b1, timer_osc:atim_async};
      atim_sync_clk_en = 1'b1;
      if (st_r == SMPC_SLEEP)
      begin
         clk_en.cpu   = 1'b0; // [R5]
         clk_en.flash = 1'b0;
         unique case (mode_r)
            `SMPC_MODE_IDLE: ;
            `SMPC_MODE_NOISE:
               clk_en.io = 1'b0; // [R8]
            `SMPC_MODE_PSAVE:
            begin
               clk_en.io  = 1'b0; // [R14] [R16]
               clk_en.adc = 1'b0;
               clk_en.asy = atim_enabled && atim_async;
               clk_en.timer_osc = atim_enabled && atim_async;
               clk_en.main_osc  = atim_enabled && !atim_async;
               atim_sync_clk_en = atim_enabled && !atim_async;
            end
            `SMPC_MODE_STBY:
            begin
               clk_en.io  = 1'b0; // [R17]
               clk_en.adc = 1'b0;
               clk_en.asy = 1'b0;
               clk_en.timer_osc = 1'b0;
               atim_sync_clk_en = 1'b0;
            end
            default:
            begin
               clk_en = '0; // [R10]
               atim_sync_clk_en = 1'b0;
            end
         endcase
      end
   end

   // gate bits act on top of the mode's own stops
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_gate
         if (g == `SMPC_GATE_ADC)
            assign periph_clk_en[g] = clk_en.adc && !gate_r[g]; // [R19]
         else if (g == `SMPC_GATE_ATIM)
            assign periph_clk_en[g] = (clk_en.io || atim_sync_clk_en)
                                      && !gate_r[g]; // [R21]
         else
            assign periph_clk_en[g] = clk_en.io && !gate_r[g]; // [R20]
      end
   endgenerate

   // one pulse on entry to idle or noise mode
   always_ff @(posedge clk)
   begin
      if (srst)
         adc_start_r <= 1'b0;
      else
         adc_start_r <= (st_r == SMPC_RUN) && go_sleep && adc_enabled &&
            (ctrl_r[`SMPC_MODE_MSB:`SMPC_MODE_LSB] <= `SMPC_MODE_NOISE);
   end // [R7]
   assign adc_start = adc_start_r;

   // ************************************************
   // assertions
   // ************************************************
   no_enable_a: assert property (@(posedge clk) disable iff (srst)
      (st_r == SMPC_RUN && sleep_exec && !ctrl_r[0]) |=> !sleeping)
      else $error("slept without enable"); // [R26]
   enter_a: assert property (@(posedge clk) disable iff (srst)
      (go_sleep && st_r == SMPC_RUN && !wake_reset) |=> sleeping)
      else $error("sleep not entered"); // [R1]
   reserved_a: assert property (@(posedge clk) disable iff (srst)
      (st_r == SMPC_RUN && ctrl_r[3:1] inside {3'h4, 3'h5, 3'h7})
      |=> st_r == SMPC_RUN)
      else $error("reserved mode slept"); // [R25]
   idle_clk_a: assert property (@(posedge clk) disable iff (srst)
      (sleeping && mode_r == 3'h0) |-> (!clk_en.cpu && clk_en.io))
      else $error("idle clocks wrong"); // [R5]
   pdown_clk_a: assert property (@(posedge clk) disable iff (srst)
      (sleeping && mode_r == 3'h2) |-> clk_en == '0)
      else $error("power-down clocks wrong"); // [R10]
   noise_clk_a: assert property (@(posedge clk) disable iff (srst)
      (sleeping && mode_r == 3'h1) |-> (!clk_en.io && clk_en.adc))
      else $error("noise clocks wrong"); // [R8]
   stby_wake_a: assert property (@(posedge clk) disable iff
      (srst || wake_reset)
      (sleeping && mode_r == 3'h6 && wake_any) |=> ##[5:7] st_r ==
      SMPC_STALL)
      else $error("standby start-up wrong"); // [R18]
   stall_a: assert property (@(posedge clk) disable iff
      (srst || wake_reset)
      $rose(st_r == SMPC_STALL) |-> (st_r == SMPC_STALL) [*4]
      ##1 st_r == SMPC_RUN)
      else $error("stall not four cycles"); // [R2]
   reset_wake_a: assert property (@(posedge clk) disable iff (srst)
      (sleeping && wake_reset) |=> (reset_vector && !core_halt))
      else $error("reset did not wake"); // [R4]
   gate_a: assert property (@(posedge clk) disable iff (srst)
      gate_r[5] |-> !periph_clk_en[5])
      else $error("gate bit ignored"); // [R19]
   rsvd_bits_a: assert property (@(posedge clk) disable iff (srst)
      ctrl_rdata[7:4] == 4'h0 && !gate_rdata[4])
      else $error("reserved bits set"); // [R22] [R24]

   idle_cov_c: cover property (@(posedge clk) sleeping && mode_r == 3'h0);
   pdown_cov_c: cover property (@(posedge clk) sleeping && mode_r == 3'h2);
   psave_cov_c: cover property (@(posedge clk) sleeping && mode_r == 3'h3);
   wake_cov_c: cover property (@(posedge clk) st_r == SMPC_STALL);
endmodule : smpc_ctrl

/* File: dv/smpc_core_model.sv */
// partner model: core issuing sleep and driving interrupt lines
module smpc_core_model
(
   // clock
   input  wire logic            clk,
   // requests from the bench
   input  wire logic            go,
   input  wire logic [8:0]      wake_req,
   // controller side
   input  wire logic            core_halt,
   output logic                 sleep_exec,
   output smpc_pkg::smpc_wake_s wake_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import smpc_pkg::*;

   logic pend_r;

   initial
   begin
      pend_r     = 1'b0;
      sleep_exec = 1'b0;
      wake_in    = '0;
   end

   always @(posedge clk)
   begin
      pend_r <= go;
   end

   // a halted core cannot execute the sleep instruction
   always @(negedge clk)
   begin
      sleep_exec <= pend_r & ~core_halt;
      wake_in    <= smpc_wake_s'(wake_req); // held until bench drops it
   end
endmodule : smpc_core_model

/* File: dv/smpc_ctrl_tb_top.sv */
// self-checking bench of the sleep mode power controller
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module smpc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import smpc_pkg::*;

   // ***************************************
   // signals
   // ***************************************
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic       ctrl_we = 1'b0;
   logic       gate_we = 1'b0;
   logic       go = 1'b0;
   logic       ige = 1'b0;
   logic       wrst = 1'b0;
   logic       xtal = 1'b0;
   logic       async = 1'b1;
   logic       ten = 1'b1;
   logic       aden = 1'b1;
   logic [7:0] ctrl_wd = 8'h00;
   logic [7:0] gate_wd = 8'h00;
   logic [8:0] wreq = 9'h000;
   logic [7:0] ctrl_rd;
   logic [7:0] gate_rd;
   logic [7:0] pce;
   logic       halt;
   logic       slp;
   logic       rvec;
   logic       sexe;
   logic       adcs;
   logic       sync_en;
   logic       a;
   smpc_wake_s win;
   smpc_clk_s  cen;
   logic [2:0] rc[4] = '{3'h4, 3'h5, 3'h7, 3'h6};
   int         errors = 0;
   int         n_tests = 0;

   always #4 clk = ~clk;

   smpc_ctrl smpc_ctrl_inst (
      .clk(clk), .srst(srst), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wd),
      .gate_we(gate_we), .gate_wdata(gate_wd), .ctrl_rdata(ctrl_rd),
      .gate_rdata(gate_rd), .sleep_exec(sexe), .irq_global_en(ige),
      .core_halt(halt), .sleeping(slp), .reset_vector(rvec),
      .wake_in(win), .wake_reset(wrst), .xtal_selected(xtal),
      .atim_async(async), .atim_enabled(ten), .adc_enabled(aden),
      .fuse_startup(16'h0003), .clk_en(cen), .periph_clk_en(pce),
      .atim_sync_clk_en(sync_en), .adc_start(adcs)
   );

   smpc_core_model smpc_core_model_inst (
      .clk(clk), .go(go), .wake_req(wreq), .core_halt(halt),
      .sleep_exec(sexe), .wake_in(win)
   );

   // ***************************************
   // tasks
   // ***************************************
   task automatic finish_test;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task automatic wr_ctrl(input logic [7:0] v);
      ctrl_wd <= v;
      ctrl_we <= 1'b1;
      @(negedge clk);
      ctrl_we <= 1'b0;
      @(negedge clk);
   endtask : wr_ctrl

   task automatic wr_gate(input logic [7:0] v);
      gate_wd <= v;
      gate_we <= 1'b1;
      @(negedge clk);
      gate_we <= 1'b0;
      @(negedge clk);
   endtask : wr_gate

   // fixed wait: sleeping follows the taken request by one cycle
   task automatic sleep_cmd(output logic adc);
      adc = 1'b0;
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      repeat (5)
      begin
         @(negedge clk);
         adc |= adcs;
      end
   endtask : sleep_cmd

   task automatic run_mode(input logic [2:0] m, input logic as, ge,
                           input logic [8:0] ign, wk,
                           input logic [6:0] ec, cm,
                           input int eh, input logic ea, es);
      logic ad;
      int   n;
      async <= as;
      ige   <= ge;
      xtal  <= (m == 3'h6);
      wr_ctrl({4'h0, m, 1'b1});
      sleep_cmd(ad);
      `CHK(slp, 1'b1)
      `CHK(cen & cm, ec & cm)
      `CHK(ad, ea)
      `CHK(sync_en, es)
      wreq <= ign;
      repeat (4) @(negedge clk);
      `CHK(slp, 1'b1)
      wreq <= wk;
      @(negedge clk);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (halt && n < 60);
      if (n == 60)
      begin
         errors++;
         finish_test();
      end
      `CHK(n - 1, eh)
      `CHK(rvec, 1'b0)
      wreq <= 9'h000;
      repeat (2) @(negedge clk);
   endtask : run_mode

   // ***************************************
   // main sequence
   // ***************************************
   initial
   begin
      repeat (20) @(negedge clk);
      srst <= 1'b0;
      @(negedge clk);
      `CHK(ctrl_rd, 8'h00)
      `CHK(gate_rd, 8'h00)
      `CHK(cen, 7'h7F)
      wr_ctrl(8'hFF);
      `CHK(ctrl_rd, 8'h0F)
      wr_gate(8'hFF);
      `CHK(gate_rd, 8'hEF)
      `CHK(pce & 8'hEF, 8'h00)
      foreach (rc[i])
      begin
         wr_ctrl({4'h0, rc[i], 1'b1});
         sleep_cmd(a);
         `CHK(slp, 1'b0)
         `CHK(cen.cpu, 1'b1)
      end
      wr_ctrl(8'h00);
      sleep_cmd(a);
      `CHK(slp, 1'b0)
      run_mode(3'h0, 1, 1, 9'h000, 9'h001, 7'h1F, 7'h7F, 5, 1, 1);
      `CHK(pce & 8'hEF, 8'h00)
      wr_gate(8'h00);
      `CHK(pce & 8'hEF, 8'hEF)
      run_mode(3'h1, 0, 1, 9'h011, 9'h004, 7'h0E, 7'h7F, 5, 1, 1);
      run_mode(3'h2, 1, 1, 9'h085, 9'h100, 7'h00, 7'h7F, 7, 0, 0);
      run_mode(3'h3, 1, 0, 9'h010, 9'h100, 7'h05, 7'h7F, 7, 0, 0);
      run_mode(3'h3, 0, 1, 9'h004, 9'h010, 7'h02, 7'h63, 7, 0, 1);
      run_mode(3'h6, 1, 1, 9'h014, 9'h040, 7'h02, 7'h7F, 10, 0, 0);
      // converter and timer switched off: no conversion in idle, no timer clocks in power-save
      aden <= 1'b0;
      ten  <= 1'b0;
      run_mode(3'h0, 1, 1, 9'h000, 9'h001, 7'h1F, 7'h7F, 5, 0, 1);
      run_mode(3'h3, 1, 1, 9'h004, 9'h100, 7'h00, 7'h7F, 7, 0, 0);
      wr_ctrl(8'h05);
      sleep_cmd(a);
      wrst <= 1'b1;
      @(negedge clk);
      wrst <= 1'b0;
      a = 1'b0;
      repeat (3)
      begin
         a |= rvec;
         @(negedge clk);
      end
      `CHK(a, 1'b1)
      `CHK(slp, 1'b0)
      finish_test();
   end
endmodule : smpc_ctrl_tb_top
